// File: logic/nvsr_host.sv
// host side pin sequencer for a shadowed sram with save and restore
`timescale 1ns/1ps
module nvsr_host #(
    parameter bit FAST_GRADE = 1'b1,
    parameter int SAVE_CYCLES = nvsr_pkg::NV_SAVE_CYCLES,
    parameter int POWERUP_CYCLES = nvsr_pkg::POWERUP_RESTORE_CYCLES
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // user command port
    input wire logic i_req,
    input wire nvsr_pkg::nvsr_cmd_t i_cmd,
    input wire logic [nvsr_pkg::ADDR_W-1:0] i_addr,
    input wire logic [nvsr_pkg::DATA_W-1:0] i_wdata,
    output logic o_ready,
    output logic o_done,
    output logic [nvsr_pkg::DATA_W-1:0] o_rdata,
    // supply monitor
    input wire logic i_supply_ok,
    // memory pins
    output logic [nvsr_pkg::ADDR_W-1:0] o_addr,
    output logic o_ce_n,
    output logic o_we_n,
    output logic o_oe_n,
    output logic [nvsr_pkg::DATA_W-1:0] o_dq_out,
    output logic o_dq_oe,
    input wire logic [nvsr_pkg::DATA_W-1:0] i_dq_in
);

    // ****************************************
    // derived constants
    // ****************************************
    localparam int TW = nvsr_pkg::TIMER_W;
    localparam int AW = nvsr_pkg::ADDR_W;
    localparam int DW = nvsr_pkg::DATA_W;
    localparam int CYCLE_NS = FAST_GRADE ? nvsr_pkg::READ_CYCLE_FAST_NS
                                         : nvsr_pkg::READ_CYCLE_SLOW_NS;
    localparam int PULSE_NS = FAST_GRADE ? nvsr_pkg::CE_PULSE_FAST_NS
                                         : nvsr_pkg::CE_PULSE_SLOW_NS;
    // low phase covers access time plus the data synchroniser
    localparam int LOW_CYC = nvsr_pkg::ceil_cycles(CYCLE_NS) + nvsr_pkg::SYNC_STAGES + 1;
    localparam logic [TW-1:0] LOW_LOAD = TW'(LOW_CYC - 1);
    localparam logic [TW-1:0] HIGH_LOAD = TW'(nvsr_pkg::RECOVERY_CYCLES - 1);
    localparam logic [TW-1:0] SAVE_LOAD = TW'(SAVE_CYCLES - 1);
    localparam logic [TW-1:0] RESTORE_LOAD = TW'(nvsr_pkg::NV_RESTORE_CYCLES - 1);
    localparam logic [TW-1:0] POWERUP_LOAD = TW'(POWERUP_CYCLES - 1);
    localparam logic [3:0] LOW_CNT = 4'(LOW_CYC);

    if (SAVE_CYCLES < 1 || SAVE_CYCLES >= 2 ** TW || POWERUP_CYCLES < 1
        || POWERUP_CYCLES >= 2 ** TW || LOW_CYC >= 16
        || LOW_CYC * nvsr_pkg::CLOCK_PERIOD_NS < PULSE_NS) begin : g_bad_param
        $error("nvsr_host parameters out of range");
    end

    typedef enum {S_OFF, S_PU_WAIT, S_IDLE, S_ADDR, S_ARM, S_LOW, S_HIGH, S_BUSY} nvsr_state_t;

    // ****************************************
    // reset and pin synchronisers
    // ****************************************
    logic rst_meta_reg;
    logic rst_n_reg;
    logic sup_meta_reg;
    logic sup_sync_reg;
    logic [DW-1:0] dq_meta_reg;
    logic [DW-1:0] dq_sync_reg;

    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rst_meta_reg <= 1'h0;
            rst_n_reg <= 1'h0;
        end
        else
        begin
            rst_meta_reg <= 1'h1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            sup_meta_reg <= 1'h0;
            sup_sync_reg <= 1'h0;
            dq_meta_reg <= '0;
            dq_sync_reg <= '0;
        end
        else
        begin
            sup_meta_reg <= i_supply_ok;
            sup_sync_reg <= sup_meta_reg;
            dq_meta_reg <= i_dq_in;
            dq_sync_reg <= dq_meta_reg;
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    nvsr_state_t state_reg, state_next;
    nvsr_pkg::nvsr_cmd_t op_reg, op_next;
    logic [2:0] step_reg, step_next;
    logic [AW-1:0] addr_reg, addr_next;
    logic [DW-1:0] wdata_reg, wdata_next;
    logic [DW-1:0] rdata_reg, rdata_next;
    logic done_reg, done_next;
    logic [AW-1:0] pin_addr_reg, pin_addr_next;
    logic ce_n_reg, ce_n_next;
    logic we_n_reg, we_n_next;
    logic oe_n_reg, oe_n_next;
    logic dq_oe_reg, dq_oe_next;
    logic load;
    logic [TW-1:0] load_value;
    logic timer_zero;
    logic is_seq;
    logic is_write;
    logic [AW-1:0] cur_addr;

    nvsr_timer #(
        .WIDTH(TW)
    ) u_timer (
        .i_clock(i_clock),
        .i_rst_n(rst_n_reg),
        .i_load(load),
        .i_value(load_value),
        .o_zero(timer_zero)
    );

    assign is_seq = (op_reg == nvsr_pkg::NVSR_CMD_SAVE) || (op_reg == nvsr_pkg::NVSR_CMD_RESTORE);
    assign is_write = (op_reg == nvsr_pkg::NVSR_CMD_WRITE);
    // top address bit held low during a sequence
    assign cur_addr = is_seq ? {1'b0, nvsr_pkg::seq_addr(step_reg,
                      op_reg == nvsr_pkg::NVSR_CMD_SAVE)} : addr_reg;

    always_comb
    begin
        state_next = state_reg;
        op_next = op_reg;
        step_next = step_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        done_next = 1'b0;
        pin_addr_next = pin_addr_reg;
        ce_n_next = 1'b1;
        we_n_next = 1'b1;
        oe_n_next = 1'b1;
        dq_oe_next = 1'b0;
        load = 1'b0;
        load_value = '0;
        if (!sup_sync_reg)
        begin
            state_next = S_OFF;
            step_next = 3'h0;
        end
        else
        begin
            case (state_reg)
                S_OFF:
                begin
                    load = 1'b1;
                    load_value = POWERUP_LOAD;
                    state_next = S_PU_WAIT;
                end
                S_PU_WAIT:
                begin
                    if (timer_zero)
                    begin
                        state_next = S_IDLE;
                    end
                end
                S_IDLE:
                begin
                    if (i_req)
                    begin
                        op_next = i_cmd;
                        addr_next = i_addr;
                        wdata_next = i_wdata;
                        step_next = 3'h0;
                        state_next = S_ADDR;
                    end
                end
                S_ADDR:
                begin
                    pin_addr_next = cur_addr;
                    state_next = S_ARM;
                end
                S_ARM, S_LOW:
                begin
                    // one falling chip enable per step, held for the whole low phase
                    ce_n_next = 1'b0;
                    we_n_next = !is_write;
                    oe_n_next = is_write;
                    dq_oe_next = is_write;
                    if (state_reg == S_ARM)
                    begin
                        load = 1'b1;
                        load_value = LOW_LOAD;
                        state_next = S_LOW;
                    end
                    else if (timer_zero)
                    begin
                        ce_n_next = 1'b1;
                        we_n_next = 1'b1;
                        oe_n_next = 1'b1;
                        dq_oe_next = 1'b0;
                        rdata_next = is_write ? rdata_reg : dq_sync_reg;
                        load = 1'b1;
                        load_value = HIGH_LOAD;
                        state_next = S_HIGH;
                    end
                end
                S_HIGH:
                begin
                    if (timer_zero)
                    begin
                        // no other access may enter a sequence
                        if (is_seq && step_reg != nvsr_pkg::LAST_STEP)
                        begin
                            step_next = step_reg + 3'h1;
                            state_next = S_ADDR;
                        end
                        else if (is_seq)
                        begin
                            load = 1'b1;
                            load_value = (op_reg == nvsr_pkg::NVSR_CMD_SAVE) ? SAVE_LOAD
                                                                            : RESTORE_LOAD;
                            state_next = S_BUSY;
                        end
                        else
                        begin
                            done_next = 1'b1;
                            state_next = S_IDLE;
                        end
                    end
                end
                S_BUSY:
                begin
                    if (timer_zero)
                    begin
                        done_next = 1'b1;
                        step_next = 3'h0;
                        state_next = S_IDLE;
                    end
                end
                default:
                begin
                    state_next = S_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            state_reg <= S_OFF;
            op_reg <= nvsr_pkg::NVSR_CMD_READ;
            step_reg <= 3'h0;
            addr_reg <= '0;
            wdata_reg <= '0;
            rdata_reg <= '0;
            done_reg <= 1'h0;
            pin_addr_reg <= '0;
            ce_n_reg <= 1'h1;
            we_n_reg <= 1'h1;
            oe_n_reg <= 1'h1;
            dq_oe_reg <= 1'h0;
        end
        else
        begin
            state_reg <= state_next;
            op_reg <= op_next;
            step_reg <= step_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            done_reg <= done_next;
            pin_addr_reg <= pin_addr_next;
            ce_n_reg <= ce_n_next;
            we_n_reg <= we_n_next;
            oe_n_reg <= oe_n_next;
            dq_oe_reg <= dq_oe_next;
        end
    end

    assign o_ready = (state_reg == S_IDLE);
    assign o_done = done_reg;
    assign o_rdata = rdata_reg;
    assign o_addr = pin_addr_reg;
    assign o_ce_n = ce_n_reg;
    assign o_we_n = we_n_reg;
    assign o_oe_n = oe_n_reg;
    assign o_dq_out = wdata_reg;
    assign o_dq_oe = dq_oe_reg;

    // ****************************************
    // checks
    // ****************************************
    logic [3:0] low_cnt_reg, low_cnt_next;
    logic [TW-1:0] wait_cnt_reg, wait_cnt_next;

    always_comb
    begin
        low_cnt_next = ce_n_reg ? 4'h0 : low_cnt_reg + 4'h1;
        wait_cnt_next = (state_reg == S_BUSY || state_reg == S_PU_WAIT) ? wait_cnt_reg + 1'b1 : '0;
    end

    always_ff @(posedge i_clock or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            low_cnt_reg <= 4'h0;
            wait_cnt_reg <= '0;
        end
        else
        begin
            low_cnt_reg <= low_cnt_next;
            wait_cnt_reg <= wait_cnt_next;
        end
    end

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!rst_n_reg);

    seq_first_addr_a: assert property ((state_reg == S_ARM && is_seq && step_reg == 3'h0)
        |-> o_addr[13:0] == nvsr_pkg::SEQ_ADDR_0) else $error("bad first prefix");
    save_trigger_a: assert property ((state_reg == S_ARM && op_reg == nvsr_pkg::NVSR_CMD_SAVE
        && step_reg == nvsr_pkg::LAST_STEP) |-> o_addr[13:0] == nvsr_pkg::SAVE_ADDR ##1 !o_ce_n)
        else $error("bad save address");
    restore_trigger_a: assert property ((state_reg == S_ARM && step_reg == nvsr_pkg::LAST_STEP
        && op_reg == nvsr_pkg::NVSR_CMD_RESTORE) |-> o_addr[13:0] == nvsr_pkg::RESTORE_ADDR)
        else $error("bad restore address");
    step_order_a: assert property ((state_reg == S_HIGH && timer_zero && is_seq && sup_sync_reg
        && step_reg != nvsr_pkg::LAST_STEP) |=> step_reg == $past(step_reg) + 3'h1
        && state_reg == S_ADDR) else $error("steps out of order");
    seq_read_only_a: assert property ((is_seq && state_reg != S_IDLE) |-> o_we_n)
        else $error("write strobe in sequence");
    top_bit_zero_a: assert property ((is_seq && !o_ce_n) |-> !o_addr[14])
        else $error("top address bit set");
    ce_pulse_len_a: assert property ($rose(o_ce_n) && sup_sync_reg |-> low_cnt_reg == LOW_CNT)
        else $error("chip enable low phase wrong");
    single_fall_a: assert property ($fell(o_ce_n) |-> $past(state_reg) == S_ARM)
        else $error("stray chip enable edge");
    save_time_a: assert property (($past(state_reg) == S_BUSY && state_reg == S_IDLE
        && op_reg == nvsr_pkg::NVSR_CMD_SAVE) |-> wait_cnt_reg == TW'(SAVE_CYCLES))
        else $error("save wait wrong");
    restore_time_a: assert property (($past(state_reg) == S_BUSY && state_reg == S_IDLE
        && op_reg == nvsr_pkg::NVSR_CMD_RESTORE) |-> wait_cnt_reg == TW'(nvsr_pkg::NV_RESTORE_CYCLES))
        else $error("restore wait wrong");
    powerup_time_a: assert property (($past(state_reg) == S_PU_WAIT && state_reg == S_IDLE)
        |-> wait_cnt_reg == TW'(POWERUP_CYCLES)) else $error("power-up wait wrong");
    write_strobe_a: assert property (!o_we_n |-> is_write && !o_ce_n && o_oe_n && o_dq_oe)
        else $error("write strobe misused");
    busy_quiet_a: assert property ((state_reg == S_BUSY) |-> o_ce_n && !o_dq_oe && !o_ready)
        else $error("access during busy");
    seq_atomic_a: assert property ((is_seq && state_reg inside {S_LOW, S_HIGH})
        |-> !o_ready && $stable(o_addr) && $stable(op_reg)) else $error("step disturbed");
    return_idle_a: assert property ((state_reg == S_BUSY && timer_zero && sup_sync_reg)
        |=> state_reg == S_IDLE && step_reg == 3'h0 && o_done) else $error("no return to idle");

endmodule : nvsr_host

// File: logic/nvsr_timer.sv
// down counter that paces pin phases and busy waits
`timescale 1ns/1ps
module nvsr_timer #(
    parameter int WIDTH = 20
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_n,
    // control
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_value,
    // status
    output logic o_zero
);

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;

    if (WIDTH < 1) begin : g_bad_width
        $error("timer width must be at least one");
    end

    always_comb
    begin
        count_next = count_reg;
        if (i_load)
        begin
            count_next = i_value;
        end
        else if (count_reg != '0)
        begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            count_reg <= '0;
        end
        else
        begin
            count_reg <= count_next;
        end
    end

    assign o_zero = (count_reg == '0);

endmodule : nvsr_timer

// File: pkg/nvsr_pkg.sv
// constants, commands and address table for the shadowed sram host sequencer
package nvsr_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int SEQ_W = 14;
    localparam int TIMER_W = 20;
    localparam int SEQ_STEPS = 6;
    localparam logic [2:0] LAST_STEP = 3'(SEQ_STEPS - 1);
    localparam int SYNC_STAGES = 2;
    localparam int RECOVERY_CYCLES = 1;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int READ_CYCLE_FAST_NS = 25;
    localparam int READ_CYCLE_SLOW_NS = 45;
    localparam int CE_PULSE_FAST_NS = 20;
    localparam int CE_PULSE_SLOW_NS = 30;
    localparam int NV_SAVE_TIME_MS = 10;
    localparam int NV_RESTORE_TIME_US = 20;
    localparam int POWERUP_RESTORE_TIME_US = 550;
    localparam int NV_SAVE_CYCLES = NV_SAVE_TIME_MS * 1000000 / CLOCK_PERIOD_NS;
    localparam int NV_RESTORE_CYCLES = NV_RESTORE_TIME_US * 1000 / CLOCK_PERIOD_NS;
    localparam int POWERUP_RESTORE_CYCLES = POWERUP_RESTORE_TIME_US * 1000 / CLOCK_PERIOD_NS;

    // ****************************************
    // sequence addresses
    // ****************************************
    localparam logic [SEQ_W-1:0] SEQ_ADDR_0 = 14'h0E38;
    localparam logic [SEQ_W-1:0] SEQ_ADDR_1 = 14'h31C7;
    localparam logic [SEQ_W-1:0] SEQ_ADDR_2 = 14'h03E0;
    localparam logic [SEQ_W-1:0] SEQ_ADDR_3 = 14'h3C1F;
    localparam logic [SEQ_W-1:0] SEQ_ADDR_4 = 14'h303F;
    localparam logic [SEQ_W-1:0] SAVE_ADDR = 14'h0FC0;
    localparam logic [SEQ_W-1:0] RESTORE_ADDR = 14'h0C63;

    // ****************************************
    // commands
    // ****************************************
    typedef enum logic [1:0] {
        NVSR_CMD_READ,
        NVSR_CMD_WRITE,
        NVSR_CMD_SAVE,
        NVSR_CMD_RESTORE
    } nvsr_cmd_t;

    function automatic int ceil_cycles(input int ns);
        return (ns + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    endfunction : ceil_cycles

    function automatic logic [SEQ_W-1:0] seq_addr(input logic [2:0] step, input logic save);
        case (step)
            3'h0: seq_addr = SEQ_ADDR_0;
            3'h1: seq_addr = SEQ_ADDR_1;
            3'h2: seq_addr = SEQ_ADDR_2;
            3'h3: seq_addr = SEQ_ADDR_3;
            3'h4: seq_addr = SEQ_ADDR_4;
            default: seq_addr = save ? SAVE_ADDR : RESTORE_ADDR;
        endcase
    endfunction : seq_addr

endpackage : nvsr_pkg

// File: sim/nvsr_dev_model.sv
// behavioural shadowed sram facing the host sequencer
`timescale 1ns/1ps
module nvsr_dev_model #(
    parameter int SAVE_NS = 200,
    parameter int RESTORE_NS = 20000,
    parameter int POWERUP_NS = 300,
    parameter int ACCESS_NS = 25,
    parameter int CE_MIN_NS = 20
) (
    // memory pins
    input wire logic i_supply_ok,
    input wire logic [14:0] i_addr,
    input wire logic i_ce_n,
    input wire logic i_we_n,
    input wire logic i_oe_n,
    input wire logic [7:0] i_dq_host,
    input wire logic i_dq_host_oe,
    output logic [7:0] o_dq_level,
    // statistics
    output int o_saves,
    output int o_restores,
    output int o_faults
);
    localparam logic [13:0] SEQ [0:4] = '{14'h0E38, 14'h31C7, 14'h03E0, 14'h3C1F, 14'h303F};
    logic [7:0] mem [0:32767];
    logic [7:0] nv [0:32767];
    logic [2:0] step_reg = 3'h0;
    logic [7:0] last_reg = 8'h00;
    logic valid_reg = 1'b0;
    realtime busy_until = 0.0;
    realtime fall_time = 0.0;
    initial
    begin
        o_saves = 0;
        o_restores = 0;
        o_faults = 0;
        foreach (nv[i]) nv[i] = 8'h00;
    end
    // ****************************************
    // power-up restore and sequence detector
    // ****************************************
    always @(posedge i_supply_ok)
    begin
        foreach (mem[i]) mem[i] = nv[i];
        busy_until = $realtime + POWERUP_NS;
    end
    always @(negedge i_supply_ok) step_reg = 3'h0;
    always @(negedge i_ce_n)
    begin
        logic [13:0] a;
        fall_time = $realtime;
        valid_reg = 1'b0;
        #1;
        a = i_addr[13:0];
        if ($realtime < busy_until) o_faults++;
        else if (!i_supply_ok || !i_we_n) step_reg = 3'h0;
        else if (step_reg == 3'h5)
        begin
            if (a == 14'h0FC0)
            begin
                foreach (mem[i]) nv[i] = mem[i];
                o_saves++;
                busy_until = $realtime + SAVE_NS;
            end
            else if (a == 14'h0C63)
            begin
                foreach (mem[i]) mem[i] = 8'h00;
                foreach (mem[i]) mem[i] = nv[i];
                o_restores++;
                busy_until = $realtime + RESTORE_NS;
            end
            step_reg = (a == SEQ[0]) ? 3'h1 : 3'h0;
        end
        else if (a == SEQ[step_reg]) step_reg++;
        else step_reg = (a == SEQ[0]) ? 3'h1 : 3'h0;
        #(ACCESS_NS - 1);
        if (!i_ce_n && i_we_n && $realtime >= busy_until) valid_reg = 1'b1;
    end
    always @(posedge i_ce_n)
    begin
        valid_reg = 1'b0;
        last_reg = o_dq_level;
        if (i_supply_ok && fall_time > 0.0 && $realtime - fall_time < CE_MIN_NS) o_faults++;
    end
    // ****************************************
    // array write and data pins
    // ****************************************
    always @(i_ce_n, i_we_n, i_addr, i_dq_host, i_dq_host_oe)
        if (!i_ce_n && !i_we_n && i_dq_host_oe && $realtime >= busy_until && i_supply_ok)
            mem[i_addr] = i_dq_host;
    always @*
        if (i_dq_host_oe) o_dq_level = i_dq_host;
        else if (valid_reg && !i_oe_n) o_dq_level = mem[i_addr];
        else o_dq_level = ~last_reg;
endmodule : nvsr_dev_model

// File: sim/tb_top.sv
// self-checking bench for the shadowed sram host sequencer
`timescale 1ns/1ps
module tb_top;
    localparam int SAVE_CYC = 20;
    localparam int PU_CYC = 30;
    localparam int RW_LAT = 9;
    localparam int SEQ_LAT = 54;
    localparam logic [13:0] SEQ_T [0:6] = '{14'h0E38, 14'h31C7, 14'h03E0, 14'h3C1F, 14'h303F,
        14'h0FC0, 14'h0C63};
    typedef struct packed {
        nvsr_pkg::nvsr_cmd_t cmd;
        logic [14:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
    } nvsr_row_t;
    localparam nvsr_row_t ROWS [0:6] = '{
        '{nvsr_pkg::NVSR_CMD_WRITE, 15'h0001, 8'hA5, 8'h00},
        '{nvsr_pkg::NVSR_CMD_WRITE, 15'h4001, 8'h5A, 8'h00},
        '{nvsr_pkg::NVSR_CMD_READ, 15'h0001, 8'h00, 8'hA5},
        '{nvsr_pkg::NVSR_CMD_READ, 15'h4001, 8'h00, 8'h5A},
        '{nvsr_pkg::NVSR_CMD_WRITE, 15'h0E38, 8'h3C, 8'h00},
        '{nvsr_pkg::NVSR_CMD_READ, 15'h0E38, 8'h00, 8'h3C},
        '{nvsr_pkg::NVSR_CMD_READ, 15'h31C7, 8'h00, 8'h00}};
    logic i_clock, i_resetn, i_req, i_supply_ok, o_ready, o_done, o_ce_n, o_we_n, o_oe_n, o_dq_oe;
    nvsr_pkg::nvsr_cmd_t i_cmd;
    logic [14:0] i_addr, o_addr;
    logic [7:0] i_wdata, o_rdata, o_dq_out, dq_level;
    int err_count, checked, saves, restores, faults, lat, n;
    logic [14:0] fall_addr [$];
    logic fall_we [$];
    nvsr_host #(.FAST_GRADE(1'b1), .SAVE_CYCLES(SAVE_CYC), .POWERUP_CYCLES(PU_CYC)) nvsr_host_i (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_req(i_req), .i_cmd(i_cmd), .i_addr(i_addr),
        .i_wdata(i_wdata), .o_ready(o_ready), .o_done(o_done), .o_rdata(o_rdata),
        .i_supply_ok(i_supply_ok), .o_addr(o_addr), .o_ce_n(o_ce_n), .o_we_n(o_we_n),
        .o_oe_n(o_oe_n), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .i_dq_in(dq_level));
    nvsr_dev_model #(.SAVE_NS(SAVE_CYC * 10), .POWERUP_NS(PU_CYC * 10)) nvsr_dev_model_i (
        .i_supply_ok(i_supply_ok), .i_addr(o_addr), .i_ce_n(o_ce_n), .i_we_n(o_we_n),
        .i_oe_n(o_oe_n), .i_dq_host(o_dq_out), .i_dq_host_oe(o_dq_oe), .o_dq_level(dq_level),
        .o_saves(saves), .o_restores(restores), .o_faults(faults));
    initial i_clock = 1'b0;
    always #5 i_clock = ~i_clock;
    always @(negedge o_ce_n)
    begin
        #1;
        fall_addr.push_back(o_addr);
        fall_we.push_back(o_we_n);
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    task automatic run_cmd(input nvsr_pkg::nvsr_cmd_t cmd, input logic [14:0] addr,
        input logic [7:0] wdata);
        n = 0;
        while (o_ready !== 1'b1 && n < 3000)
        begin
            @(negedge i_clock);
            n++;
        end
        i_req = 1'b1;
        i_cmd = cmd;
        i_addr = addr;
        i_wdata = wdata;
        @(negedge i_clock);
        i_req = 1'b0;
        lat = 0;
        while (o_done !== 1'b1 && lat < 3000)
        begin
            @(negedge i_clock);
            lat++;
        end
        if (n >= 3000 || lat >= 3000)
        begin
            err_count++;
            $display("[FAIL] %0t command timed out", $time);
            wrap_up();
        end
    endtask : run_cmd
    task automatic nv_cmd(input logic save, input int exp_lat);
        fall_addr.delete();
        fall_we.delete();
        run_cmd(save ? nvsr_pkg::NVSR_CMD_SAVE : nvsr_pkg::NVSR_CMD_RESTORE, 15'h0000, 8'h00);
        check(lat, exp_lat, "nv latency");
        check(fall_addr.size(), 6, "sequence length");
        for (int i = 0; i < 6; i++)
        begin
            check(fall_addr[i], {1'b0, SEQ_T[(i == 5 && !save) ? 6 : i]}, "seq address");
            check(fall_we[i], 1'b1, "strobe in sequence");
        end
    endtask : nv_cmd
    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        repeat (20000) @(posedge i_clock);
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end
    initial
    begin
        {i_resetn, i_supply_ok, i_req, i_addr, i_wdata} = '0;
        i_cmd = nvsr_pkg::NVSR_CMD_READ;
        repeat (2) @(negedge i_clock);
        i_supply_ok = 1'b1;
        repeat (3) @(negedge i_clock);
        check(o_ce_n, 1'b1, "ce idle in reset");
        check(o_ready, 1'b0, "ready in reset");
        i_resetn = 1'b1;
        run_cmd(nvsr_pkg::NVSR_CMD_READ, 15'h0000, 8'h00);
        check(n >= PU_CYC && n < PU_CYC + 10, 1'b1, "power-up wait");
        $display("test power-up done");
        foreach (ROWS[r])
        begin
            run_cmd(ROWS[r].cmd, ROWS[r].addr, ROWS[r].wdata);
            check(lat, RW_LAT, "access latency");
            if (ROWS[r].cmd == nvsr_pkg::NVSR_CMD_READ)
                check(o_rdata, ROWS[r].rdata, "read data");
        end
        $display("test rows done");
        nv_cmd(1'b1, SEQ_LAT + SAVE_CYC);
        check(saves, 1, "save count");
        run_cmd(nvsr_pkg::NVSR_CMD_WRITE, 15'h0001, 8'h77);
        nv_cmd(1'b0, SEQ_LAT + 2000);
        check(restores, 1, "restore count");
        run_cmd(nvsr_pkg::NVSR_CMD_READ, 15'h0001, 8'h00);
        check(o_rdata, 8'hA5, "restored data");
        $display("test save and restore done");
        run_cmd(nvsr_pkg::NVSR_CMD_WRITE, 15'h0001, 8'h11);
        i_req = 1'b1;
        i_cmd = nvsr_pkg::NVSR_CMD_SAVE;
        @(negedge i_clock);
        i_req = 1'b0;
        repeat (30) @(negedge i_clock);
        i_supply_ok = 1'b0;
        repeat (5) @(negedge i_clock);
        check(o_ce_n, 1'b1, "pins idle on supply loss");
        check(saves, 1, "aborted save");
        i_supply_ok = 1'b1;
        run_cmd(nvsr_pkg::NVSR_CMD_READ, 15'h0001, 8'h00);
        check(o_rdata, 8'hA5, "power-up restored data");
        $display("test supply loss done");
        i_resetn = 1'b0;
        @(negedge i_clock);
        check(o_ready, 1'b0, "ready in second reset");
        i_resetn = 1'b1;
        run_cmd(nvsr_pkg::NVSR_CMD_READ, 15'h4001, 8'h00);
        check(o_rdata, 8'h5A, "data after reset");
        check(faults, 0, "device access faults");
        $display("test second reset done");
        wrap_up();
    end
endmodule : tb_top
